//--- dcai_pkg.sv
// Package with constants and types shared by the DDR3 command/address ends.
package dcai_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int NUM_BANKS = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int BA_SEL_W = 2;
  localparam int CLK_MHZ = 125;
  localparam int REF_NORM_NS = 7800;
  localparam int REF_HOT_NS = 3900;
  localparam int REF_NORM_CYC = (REF_NORM_NS * CLK_MHZ) / 1000;
  localparam int REF_HOT_CYC = (REF_HOT_NS * CLK_MHZ) / 1000;
  // Mode op-code fields (device-local layout).
  localparam int MR_BL_BIT = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_AL_LSB = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CLM1 = 2'h1;
  localparam logic [1:0] AL_CLM2 = 2'h2;
  localparam logic [3:0] CL_RESET = 4'h9;
  // Command code {csN, rasN, casN, weN}.
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } dcai_cmd_t;
endpackage

//--- dcai_if.sv
// Interface carrying the DDR3 command, address and clocking pins.
`timescale 1ns/100ps
interface dcai_if;
  logic ckT;
  logic ckC;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [dcai_pkg::BANK_W-1:0] ba;
  logic [dcai_pkg::ADDR_W-1:0] addr;
  logic [1:0] dqsT;
  logic [1:0] dqsC;
  logic [15:0] dqH;
  logic [15:0] dqD;
  logic dqOeD;
  logic dqOeH;
  modport ctrl (output ckT, ckC, cke, csN, rasN, casN, weN, ba, addr,
    dqH, dqOeH, input dqsT, dqsC, dqD, dqOeD);
  modport dev (input ckT, ckC, cke, csN, rasN, casN, weN, ba, addr,
    dqH, dqOeH, output dqsT, dqsC, dqD, dqOeD);
endinterface

//--- dcai_device.sv
// Device end: samples pins, decodes commands, tracks banks and modes.
`timescale 1ns/100ps
module dcai_device #(
  parameter int NBANK = dcai_pkg::NUM_BANKS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Memory pins.
  dcai_if.dev pins,
  // User-side status.
  output logic [NBANK-1:0] bankOpen,
  output logic [NBANK*dcai_pkg::ADDR_W-1:0] openRows,
  output logic [dcai_pkg::BANK_W-1:0] colBank,
  output logic [dcai_pkg::COL_W-1:0] colAddr,
  output logic colValid,
  output logic colWrite,
  output logic colAutoPre,
  output logic colChop,
  output logic [dcai_pkg::ADDR_W-1:0] modeOp,
  output logic [dcai_pkg::BA_SEL_W-1:0] modeSel,
  output logic burstLen8,
  output logic burstInterleave,
  output logic [1:0] addLatency,
  output logic powerDown,
  output logic activePowerDown,
  output logic selfRefresh,
  output logic clkRunning
);
  initial begin
    if (NBANK != dcai_pkg::NUM_BANKS) $error("NBANK must be eight");
    if ((1 << dcai_pkg::BANK_W) < NBANK) $error("bank address too narrow");
    if (dcai_pkg::COL_W > dcai_pkg::AP_BIT) $error("column hits precharge bit");
    if (dcai_pkg::BC_BIT >= dcai_pkg::ADDR_W) $error("chop bit outside address");
  end
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_PD = 3'h2,
    ST_SR = 3'h4
  } dcai_pwr_t;
  typedef struct packed {
    logic [1:0] ckT;
    logic [1:0] ckC;
    logic [1:0] cke;
    logic [1:0] csN;
    logic [1:0] rasN;
    logic [1:0] casN;
    logic [1:0] weN;
    logic [1:0][dcai_pkg::BANK_W-1:0] ba;
    logic [1:0][dcai_pkg::ADDR_W-1:0] addr;
    logic ckSeen;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][dcai_pkg::ADDR_W-1:0] row;
    logic [dcai_pkg::BANK_W-1:0] cBank;
    logic [dcai_pkg::COL_W-1:0] cAddr;
    logic cValid;
    logic cWrite;
    logic cAp;
    logic cChop;
    logic [dcai_pkg::ADDR_W-1:0] op;
    logic [dcai_pkg::BA_SEL_W-1:0] sel;
    logic bl8;
    logic bt;
    logic [1:0] al;
    logic act;
    dcai_pwr_t pwr;
  } dcai_dev_st_t;
  dcai_dev_st_t st_reg;
  dcai_dev_st_t st_next;
  logic rise;
  logic [3:0] cmd;
  logic [dcai_pkg::BANK_W-1:0] ba;
  logic [dcai_pkg::ADDR_W-1:0] ad;
  logic [dcai_pkg::BA_SEL_W-1:0] mrSel;
  logic [1:0] alCode;
  always_comb begin
    st_next = st_reg;
    // Two-flop synchronisers on every clock, clock-enable, command and address pin.
    st_next.ckT = {st_reg.ckT[0], pins.ckT};
    st_next.ckC = {st_reg.ckC[0], pins.ckC};
    st_next.cke = {st_reg.cke[0], pins.cke};
    st_next.csN = {st_reg.csN[0], pins.csN};
    st_next.rasN = {st_reg.rasN[0], pins.rasN};
    st_next.casN = {st_reg.casN[0], pins.casN};
    st_next.weN = {st_reg.weN[0], pins.weN};
    st_next.ba = {st_reg.ba[0], pins.ba};
    st_next.addr = {st_reg.addr[0], pins.addr};
    st_next.ckSeen = st_reg.ckT[1] & ~st_reg.ckC[1];
    // True clock high and complement low after being otherwise.
    rise = st_reg.ckT[1] & ~st_reg.ckC[1] & ~st_reg.ckSeen;
    cmd = {st_reg.csN[1], st_reg.rasN[1], st_reg.casN[1], st_reg.weN[1]};
    ba = st_reg.ba[1];
    ad = st_reg.addr[1];
    mrSel = ba[dcai_pkg::BA_SEL_W-1:0];
    alCode = ad[dcai_pkg::MR_AL_LSB +: 2];
    st_next.cValid = 1'b0;
    if (rise) begin
      unique case (st_reg.pwr)
        ST_RUN: begin
          if (!st_reg.cke[1]) begin
            // Clock suspended from here; state below stays frozen.
            st_next.act = |st_reg.open;
            // A refresh with a bank still open falls back to power-down.
            if (cmd == dcai_pkg::CMD_REF && ~|st_reg.open) begin
              st_next.pwr = ST_SR;
            end else begin
              st_next.pwr = ST_PD;
            end
          end else if (!cmd[3]) begin
            unique case (cmd)
              dcai_pkg::CMD_ACT: begin
                st_next.open[ba] = 1'b1;
                st_next.row[ba] = ad;
              end
              dcai_pkg::CMD_PRE: begin
                if (ad[dcai_pkg::AP_BIT]) begin
                  st_next.open = '0;
                end else begin
                  st_next.open[ba] = 1'b0;
                end
              end
              dcai_pkg::CMD_RD, dcai_pkg::CMD_WR: begin
                st_next.cValid = 1'b1;
                st_next.cWrite = ~cmd[0];
                st_next.cBank = ba;
                st_next.cAddr = ad[dcai_pkg::COL_W-1:0];
                st_next.cAp = ad[dcai_pkg::AP_BIT];
                st_next.cChop = ~ad[dcai_pkg::BC_BIT];
                // Auto-precharge closes the bank as the column is taken.
                if (ad[dcai_pkg::AP_BIT]) begin
                  st_next.open[ba] = 1'b0;
                end
              end
              dcai_pkg::CMD_MRS: begin
                st_next.op = ad;
                st_next.sel = mrSel;
                if (mrSel == 2'h0) begin
                  st_next.bl8 = ~ad[dcai_pkg::MR_BL_BIT];
                  st_next.bt = ad[dcai_pkg::MR_BT_BIT];
                end else if (mrSel == 2'h1) begin
                  // The fourth code is reserved; the old setting stays.
                  if (alCode inside {dcai_pkg::AL_ZERO,
                      dcai_pkg::AL_CLM1, dcai_pkg::AL_CLM2}) begin
                    st_next.al = alCode;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_PD, ST_SR: begin
          // The waking crossing carries no command; it restarts the clock.
          if (st_reg.cke[1]) begin
            st_next.pwr = ST_RUN;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= '0;
      // Idle-high pins reset high so that no false command follows reset.
      st_reg.ckC <= 2'h3;
      st_reg.cke <= 2'h0;
      st_reg.csN <= 2'h3;
      st_reg.rasN <= 2'h3;
      st_reg.casN <= 2'h3;
      st_reg.weN <= 2'h3;
      st_reg.bl8 <= 1'b1;
      st_reg.al <= dcai_pkg::AL_ZERO;
      st_reg.pwr <= ST_RUN;
    end else begin
      st_reg <= st_next;
    end
  end
  // Read data and strobes are not modelled; pins stay released.
  assign pins.dqsT = 2'h0;
  assign pins.dqsC = 2'h3;
  assign pins.dqD = 16'h0000;
  assign pins.dqOeD = 1'b1;
  assign bankOpen = st_reg.open;
  generate
    for (genvar g = 0; g < NBANK; g++) begin : g_row
      assign openRows[g*dcai_pkg::ADDR_W +: dcai_pkg::ADDR_W] =
        st_reg.row[g];
    end
  endgenerate
  assign colBank = st_reg.cBank;
  assign colAddr = st_reg.cAddr;
  assign colValid = st_reg.cValid;
  assign colWrite = st_reg.cWrite;
  assign colAutoPre = st_reg.cAp;
  assign colChop = st_reg.cChop;
  assign modeOp = st_reg.op;
  assign modeSel = st_reg.sel;
  assign burstLen8 = st_reg.bl8;
  assign burstInterleave = st_reg.bt;
  assign addLatency = st_reg.al;
  // Power status is decoded from the registered state, so it is glitch free.
  assign powerDown = (st_reg.pwr == ST_PD);
  assign activePowerDown = (st_reg.pwr == ST_PD) & st_reg.act;
  assign selfRefresh = (st_reg.pwr == ST_SR);
  assign clkRunning = (st_reg.pwr == ST_RUN);
endmodule // dcai_device

//--- dcai_ctrl.sv
// Controller end: drives clock pair and commands, keeps refresh cadence.
`timescale 1ns/100ps
module dcai_ctrl #(
  parameter int REF_NORM = dcai_pkg::REF_NORM_CYC,
  parameter int REF_HOT = dcai_pkg::REF_HOT_CYC,
  parameter int CK_HALF = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Memory pins.
  dcai_if.ctrl pins,
  // User command request.
  input wire logic reqValid,
  input wire logic [3:0] reqCmd,
  input wire logic [dcai_pkg::BANK_W-1:0] reqBank,
  input wire logic [dcai_pkg::ADDR_W-1:0] reqAddr,
  input wire logic reqCke,
  input wire logic hot,
  output logic reqReady,
  output logic refDue
);
  initial begin
    if (REF_HOT < 1 || REF_NORM < REF_HOT || CK_HALF < 4 || CK_HALF > 256) begin
      $error("bad controller parameters");
    end
  end
  typedef struct packed {
    logic [7:0] div;
    logic ck;
    logic [31:0] refCnt;
    logic due;
    logic cke;
    logic [3:0] cmd;
    logic [dcai_pkg::BANK_W-1:0] ba;
    logic [dcai_pkg::ADDR_W-1:0] ad;
  } dcai_ctl_st_t;
  dcai_ctl_st_t st_reg;
  dcai_ctl_st_t st_next;
  logic slot;
  always_comb begin
    st_next = st_reg;
    st_next.div = st_reg.div + 8'h01;
    slot = 1'b0;
    if (st_reg.div == 8'(CK_HALF - 1)) begin
      st_next.div = 8'h00;
      st_next.ck = ~st_reg.ck;
      // Change pins at the falling crossing, centred on the rising one.
      slot = st_reg.ck;
    end
    if (slot) begin
      st_next.cmd = dcai_pkg::CMD_NOP;
      if (reqValid) begin
        st_next.cmd = reqCmd;
        st_next.ba = reqBank;
        st_next.ad = reqAddr;
        st_next.cke = reqCke;
        if (reqCmd == dcai_pkg::CMD_REF) begin
          st_next.due = 1'b0;
        end
      end
    end
    // The expiry comes after the clear, so a refresh tick is never lost.
    if (st_reg.refCnt == 32'h0) begin
      st_next.due = 1'b1;
      st_next.refCnt = hot ? 32'(REF_HOT - 1) :
        32'(REF_NORM - 1);
    end else begin
      st_next.refCnt = st_reg.refCnt - 32'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.cmd <= dcai_pkg::CMD_DES;
      st_reg.refCnt <= 32'(REF_NORM - 1);
    end else begin
      st_reg <= st_next;
    end
  end
  assign reqReady = slot;
  assign refDue = st_reg.due;
  assign pins.ckT = st_reg.ck;
  assign pins.ckC = ~st_reg.ck;
  assign pins.cke = st_reg.cke;
  assign pins.csN = st_reg.cmd[3];
  assign pins.rasN = st_reg.cmd[2];
  assign pins.casN = st_reg.cmd[1];
  assign pins.weN = st_reg.cmd[0];
  assign pins.ba = st_reg.ba;
  assign pins.addr = st_reg.ad;
  assign pins.dqH = 16'h0000;
  assign pins.dqOeH = 1'b1;
endmodule // dcai_ctrl

//--- dcai_checker.sv
// Assertions on the pins between the two ends.
`timescale 1ns/100ps
module dcai_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pins.
  input wire logic ckT,
  input wire logic ckC,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [dcai_pkg::BANK_W-1:0] ba,
  input wire logic [dcai_pkg::ADDR_W-1:0] addr,
  input wire logic dqOeD
);
  wire [19:0] cmdBus = {csN, rasN, casN, weN, ba, addr};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_high; ckT [*4] ##1 !ckT; endsequence
  sequence s_low; !ckT [*4] ##1 ckT; endsequence
  a_ck_pair: assert property (ckC == !ckT)
    else $error("Clock pair not complementary.");
  a_high_span: assert property ($rose(ckT) |-> s_high)
    else $error("Clock high phase wrong.");
  a_low_span: assert property ($fell(ckT) |-> s_low)
    else $error("Clock low phase wrong.");
  a_cmd_move: assert property ($changed(cmdBus) |-> $fell(ckT))
    else $error("Command moved off the falling clock.");
  a_cke_move: assert property ($changed(cke) |-> $fell(ckT))
    else $error("Clock enable moved off the falling clock.");
  a_cmd_setup:
    assert property ($rose(ckT) |-> cmdBus == $past(cmdBus, 3))
    else $error("Command not settled before crossing.");
  a_cmd_hold:
    assert property ($rose(ckT) |=> $stable(cmdBus) [*3])
    else $error("Command not held after crossing.");
  a_dq_free: assert property (dqOeD)
    else $error("Data pins driven without a strobe.");
endmodule // dcai_checker

//--- tb_top.sv
// Bench joining both ends and checking them against a model.
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reqValid = 1'b0;
  logic [3:0] reqCmd = 4'h8;
  logic [2:0] reqBank = 3'h0;
  logic [12:0] reqAddr = 13'h0000;
  logic reqCke = 1'b1;
  logic hot = 1'b0;
  logic reqReady, refDue, colValid, colWrite, colAutoPre, colChop;
  logic burstLen8, burstInterleave, powerDown, activePowerDown;
  logic selfRefresh, clkRunning;
  logic [7:0] bankOpen;
  logic [103:0] openRows;
  logic [2:0] colBank;
  logic [9:0] colAddr;
  logic [12:0] modeOp, r;
  logic [1:0] modeSel, addLatency;
  logic [1:0] mAl = 2'h0;
  logic [7:0] mOpen = 8'h00;
  logic mBl8 = 1'b1;
  logic mIl = 1'b0;
  logic [15:0] colQ[$];
  int n_fail = 0, n_compared = 0, gap = 0, k, i;
  time tRise = 0;
  wire [15:0] colSeen = {colBank, colAddr, colWrite, colAutoPre, colChop};
  dcai_if pins ();
  dcai_ctrl #(.REF_NORM(40), .REF_HOT(20)) u_dcai_ctrl (.clk_sys, .rst_b,
    .pins, .reqValid, .reqCmd, .reqBank, .reqAddr, .reqCke, .hot,
    .reqReady, .refDue);
  dcai_device u_dcai_device (.clk_sys, .rst_b, .pins, .bankOpen, .openRows,
    .colBank, .colAddr, .colValid, .colWrite, .colAutoPre, .colChop,
    .modeOp, .modeSel, .burstLen8, .burstInterleave, .addLatency,
    .powerDown, .activePowerDown, .selfRefresh, .clkRunning);
  dcai_checker u_dcai_checker (.clk_sys, .rst_b, .ckT(pins.ckT),
    .ckC(pins.ckC), .cke(pins.cke), .csN(pins.csN), .rasN(pins.rasN),
    .casN(pins.casN), .weN(pins.weN), .ba(pins.ba), .addr(pins.addr),
    .dqOeD(pins.dqOeD));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Holds the request until the controller takes it, then lets it land.
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
      input logic [12:0] a, input logic ck);
    int w;
    w = 0;
    {reqValid, reqCmd, reqBank, reqAddr, reqCke} <= {1'b1, c, b, a, ck};
    do @(negedge clk_sys);
    while (reqReady !== 1'b1 && ++w < 64);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    if (w >= 64) n_fail++;
    repeat (14) @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (colValid === 1'b1)
    chk("col", colSeen, colQ.size() ? colQ.pop_front() : 16'hXXXX);
  end
  always @(posedge refDue) begin
    gap = int'(($time - tRise) / 8);
    tRise = $time;
  end
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32'hCFC82E38));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 0; k < 2; k++) begin
      hot <= k[0];
      repeat (3) begin
        i = 0;
        do @(negedge clk_sys);
        while (refDue !== 1'b1 && ++i < 99);
        if (i >= 99) n_fail++;
        @(posedge clk_sys);
        cmd(4'h1, 3'h0, 13'h0000, 1'b1);
      end
      chk("refGap", gap, k ? 20 : 40);
    end
    done("refresh");
    for (k = 0; k < 8; k++) begin
      r = 13'($urandom);
      cmd(4'h3, k[2:0], r, 1'b1);
      mOpen[k] = 1'b1;
      chk("row", openRows[k*13 +: 13], r);
      chk("open", bankOpen, mOpen);
    end
    cmd(4'hA, 3'h2, 13'h0400, 1'b1);
    chk("open", bankOpen, mOpen);
    done("activate");
    cmd(4'h7, 3'h0, 13'h0000, 1'b0);
    chk("pd", {powerDown, activePowerDown, clkRunning}, 3'h6);
    cmd(4'h2, 3'h1, 13'h0000, 1'b0);
    chk("open", bankOpen, mOpen);
    cmd(4'h7, 3'h0, 13'h0000, 1'b1);
    chk("pd", {powerDown, activePowerDown, clkRunning}, 3'h1);
    done("active powerdown");
    for (k = 0; k < 8; k++) begin
      r = 13'($urandom) & 13'h1BFF | (k > 5 ? 13'h0400 : 13'h0000);
      colQ.push_back({k[2:0], r[9:0], ~k[0], r[10], ~r[12]});
      cmd({3'h2, k[0]}, k[2:0], r, 1'b1);
      mOpen[k] = mOpen[k] & ~r[10];
    end
    chk("open", bankOpen, mOpen);
    chk("colLeft", colQ.size(), 0);
    cmd(4'h2, 3'h0, 13'h0000, 1'b1);
    mOpen[0] = 1'b0;
    chk("open", bankOpen, mOpen);
    cmd(4'h2, 3'h3, 13'h0400, 1'b1);
    chk("open", bankOpen, 8'h00);
    done("column");
    cmd(4'h7, 3'h0, 13'h0000, 1'b0);
    chk("pd", {powerDown, activePowerDown, selfRefresh}, 3'h4);
    cmd(4'h7, 3'h0, 13'h0000, 1'b1);
    cmd(4'h1, 3'h0, 13'h0000, 1'b0);
    chk("sr", {selfRefresh, clkRunning}, 2'h2);
    cmd(4'h7, 3'h0, 13'h0000, 1'b1);
    chk("sr", {selfRefresh, clkRunning}, 2'h1);
    done("self refresh");
    for (k = 0; k < 8; k++) begin
      r = 13'($urandom) & 13'h1FE7 | 13'(((k / 2) % 4) << 3);
      cmd(4'h0, {2'h0, k[0]}, r, 1'b1);
      if (!k[0]) {mBl8, mIl} = {~r[0], r[3]};
      else if (r[4:3] != 2'h3) mAl = r[4:3];
      chk("op", {modeSel, modeOp}, {1'b0, k[0], r});
      chk("mode", {burstLen8, burstInterleave, addLatency},
        {mBl8, mIl, mAl});
    end
    done("mode");
    close_out();
  end
endmodule // tb_top
